// ===== verilog/flash_protect_cmd_regs.sv
// data flash protection, command object, option and reserved flash registers on wishbone
module flash_protect_cmd_regs (
	// clock and reset
	input  wire logic                                   clock,
	input  wire logic                                   rst_b,
	// wishbone slave
	input  wire logic                                   cyc_i,
	input  wire logic                                   stb_i,
	input  wire logic                                   we_i,
	input  wire logic [flash_regs_pkg::ADR_W-1:0]       adr_i,
	input  wire logic [3:0]                             sel_i,
	input  wire logic [31:0]                            dat_i,
	output logic      [31:0]                            dat_o,
	output logic                                        ack_o,
	// nonvolatile bytes fetched during the reset sequence
	input  wire logic                                   nv_load,
	input  wire logic [7:0]                             nv_protection_byte,
	input  wire logic                                   nv_protection_fault,
	input  wire logic [7:0]                             nv_option_byte,
	input  wire logic                                   nv_option_fault,
	// memory controller
	output flash_regs_pkg::controller_request_type      ctl_request,
	input  wire flash_regs_pkg::controller_result_type  ctl_result,
	input  wire logic [2:0]                             ctl_rd_index,
	output logic      [15:0]                            ctl_rd_data,
	// protection and status seen by the controller
	output logic                                        command_complete_flag,
	output logic                                        protection_open,
	output logic      [3:0]                             protection_size,
	output logic      [7:0]                             nonvolatile_option_bits
);

	flash_regs_pkg::regs_state_type state;
	flash_regs_pkg::regs_state_type next_state;

	logic                                    req;
	logic                                    wr;
	logic                                    rd;
	logic [flash_regs_pkg::IDX_W-1:0]        reg_idx;
	logic                                    idle;
	logic                                    index_valid;
	logic [4:0]                              prot_blocks;
	logic [17:0]                             prot_last;
	logic                                    any_protected;
	logic                                    addr_hit;
	logic                                    in_dflash;
	logic                                    refuse;
	logic                                    status_wr;
	logic                                    launch_req;
	logic                                    prot_wr;
	logic                                    prot_ok;
	logic                                    cob_cpu_wr;
	logic                                    store_wr_en;
	logic [2:0]                              store_wr_index;
	logic [1:0]                              store_wr_byte_en;
	logic [15:0]                             store_wr_data;
	logic [15:0]                             cpu_cob_data;
	logic [15:0]                             cob_rdata;

	// one access per request; the ack cycle itself takes nothing
	assign req     = cyc_i && stb_i && !state.ack;
	assign wr      = req && we_i;
	assign rd      = req && !we_i;
	assign reg_idx = adr_i[flash_regs_pkg::ADR_W-1:2];
	assign idle    = (state.cmd_state == flash_regs_pkg::CMD_IDLE);

	assign index_valid = (state.index < flash_regs_pkg::COB_IDX_LIMIT);

	// protected window of data flash
	assign prot_blocks   = {1'b0, state.protection_size} + 5'h01;
	assign prot_last     = flash_regs_pkg::DFLASH_BASE + {5'h00, prot_blocks, 8'h00} - 18'h00001;
	assign any_protected = !state.protection_open;
	assign in_dflash     = (state.address >= flash_regs_pkg::DFLASH_BASE) &&
	                       (state.address <= flash_regs_pkg::DFLASH_LAST);
	assign addr_hit      = any_protected && (state.address >= flash_regs_pkg::DFLASH_BASE) &&
	                       (state.address <= prot_last);

	// commands that would alter protected data flash are stopped here
	always_comb begin
		refuse = 1'b0;
		case (state.code)
			flash_regs_pkg::CMD_PROGRAM_DFLASH,
			flash_regs_pkg::CMD_ERASE_DFLASH_SECT: begin
				refuse = addr_hit;
			end
			flash_regs_pkg::CMD_ERASE_BLOCK: begin
				refuse = in_dflash && any_protected;
			end
			flash_regs_pkg::CMD_ERASE_ALL: begin
				refuse = any_protected;
			end
			default: begin
				refuse = 1'b0;
			end
		endcase
	end

	assign status_wr  = wr && sel_i[0] && (reg_idx == flash_regs_pkg::IDX_FLASH_STATUS);
	assign launch_req = status_wr && dat_i[flash_regs_pkg::COMPLETE_FLAG_BIT] && idle;

	// protection may only be added; a reducing write is dropped whole
	assign prot_wr = wr && sel_i[0] && (reg_idx == flash_regs_pkg::IDX_DFLASH_PROTECTION);
	assign prot_ok = (dat_i[3:0] >= state.protection_size) &&
	                 !(!state.protection_open && dat_i[flash_regs_pkg::PROTECTION_OPEN_BIT]);

	// cpu write into the command object, ignored while busy or at an unused index
	assign cob_cpu_wr = wr && (sel_i[1:0] != 2'b00) && idle && index_valid &&
	                    (reg_idx == flash_regs_pkg::IDX_COMMAND_OBJECT);
	assign cpu_cob_data = {dat_i[15:8],
	                       (state.index == flash_regs_pkg::COB_IDX_CODE) ?
	                       {6'h00, dat_i[1:0]} : dat_i[7:0]};

	// controller owns the write port while a command runs
	always_comb begin
		if (!idle) begin
			store_wr_en      = ctl_result.wr_en;
			store_wr_index   = ctl_result.wr_index;
			store_wr_byte_en = 2'b11;
			store_wr_data    = ctl_result.wr_data;
		end else begin
			store_wr_en      = cob_cpu_wr;
			store_wr_index   = state.index;
			store_wr_byte_en = sel_i[1:0];
			store_wr_data    = cpu_cob_data;
		end
	end

	command_object_store #(
		.WORDS (flash_regs_pkg::COB_WORDS),
		.WIDTH (flash_regs_pkg::COB_WIDTH)
	) u_store (
		.clock      (clock),
		.rst_b      (rst_b),
		.wr_en      (store_wr_en),
		.wr_index   (store_wr_index),
		.wr_byte_en (store_wr_byte_en),
		.wr_data    (store_wr_data),
		.rd_a_index (state.index),
		.rd_a_data  (cob_rdata),
		.rd_b_index (ctl_rd_index),
		.rd_b_data  (ctl_rd_data)
	);

	always_comb begin
		next_state        = state;
		next_state.ack    = req;
		next_state.launch = 1'b0;

		// nonvolatile load, accepted once per reset
		if (nv_load && !state.nv_loaded) begin
			next_state.nv_loaded = 1'b1;
			if (nv_protection_fault) begin
				next_state.protection_open = flash_regs_pkg::PROTECTION_FAULT[7];
				next_state.protection_size = flash_regs_pkg::PROTECTION_FAULT[3:0];
			end else begin
				next_state.protection_open = nv_protection_byte[7];
				next_state.protection_size = nv_protection_byte[3:0];
			end
			next_state.option = nv_option_fault ? flash_regs_pkg::OPTION_FAULT :
			                    nv_option_byte;
		end

		if (prot_wr && prot_ok) begin
			next_state.protection_open = dat_i[flash_regs_pkg::PROTECTION_OPEN_BIT];
			next_state.protection_size = dat_i[3:0];
		end

		if (wr && sel_i[0] && idle && (reg_idx == flash_regs_pkg::IDX_COMMAND_INDEX)) begin
			next_state.index = dat_i[2:0];
		end

		// shadow of code and address for the protection check
		if (cob_cpu_wr && state.index == flash_regs_pkg::COB_IDX_CODE) begin
			if (sel_i[1]) begin
				next_state.code = dat_i[15:8];
			end
			if (sel_i[0]) begin
				next_state.address[17:16] = dat_i[1:0];
			end
		end
		if (cob_cpu_wr && state.index == flash_regs_pkg::COB_IDX_ADDRESS) begin
			if (sel_i[1]) begin
				next_state.address[15:8] = dat_i[15:8];
			end
			if (sel_i[0]) begin
				next_state.address[7:0] = dat_i[7:0];
			end
		end

		// write one to clear the error flags
		if (status_wr && dat_i[flash_regs_pkg::ACCESS_ERROR_BIT]) begin
			next_state.access_error = 1'b0;
		end
		if (status_wr && dat_i[flash_regs_pkg::VIOLATION_BIT]) begin
			next_state.violation = 1'b0;
		end

		case (state.cmd_state)
			flash_regs_pkg::CMD_IDLE: begin
				if (launch_req && refuse) begin
					next_state.violation = 1'b1;
				end else if (launch_req) begin
					next_state.cmd_state = flash_regs_pkg::CMD_BUSY;
					next_state.launch    = 1'b1;
				end
			end
			flash_regs_pkg::CMD_BUSY: begin
				if (ctl_result.access_error) begin
					next_state.access_error = 1'b1;
				end
				if (ctl_result.done) begin
					next_state.cmd_state = flash_regs_pkg::CMD_IDLE;
				end
			end
			default: begin
				next_state.cmd_state = flash_regs_pkg::CMD_IDLE;
			end
		endcase

		// read data, zero for reserved and unmapped words
		next_state.dat = 32'h00000000;
		if (rd) begin
			case (reg_idx)
				flash_regs_pkg::IDX_COMMAND_INDEX: begin
					next_state.dat = {29'h0, state.index};
				end
				flash_regs_pkg::IDX_FLASH_STATUS: begin
					next_state.dat = {24'h0, idle, 1'b0, state.access_error, state.violation, 4'h0};
				end
				flash_regs_pkg::IDX_DFLASH_PROTECTION: begin
					next_state.dat = {24'h0, state.protection_open, 3'h0,
					                  state.protection_size};
				end
				flash_regs_pkg::IDX_COMMAND_OBJECT: begin
					next_state.dat = index_valid ? {16'h0, cob_rdata} : 32'h00000000;
				end
				flash_regs_pkg::IDX_NV_OPTION_BYTE: begin
					next_state.dat = {24'h0, state.option};
				end
				flash_regs_pkg::IDX_FACTORY_RESERVED_1,
				flash_regs_pkg::IDX_FACTORY_RESERVED_2,
				flash_regs_pkg::IDX_FACTORY_RESERVED_3,
				flash_regs_pkg::IDX_FACTORY_RESERVED_4,
				flash_regs_pkg::IDX_FACTORY_RESERVED_5,
				flash_regs_pkg::IDX_FACTORY_RESERVED_6,
				flash_regs_pkg::IDX_FACTORY_RESERVED_7: begin
					next_state.dat = 32'h00000000;
				end
				default: begin
					next_state.dat = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state <= flash_regs_pkg::STATE_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign dat_o                   = state.dat;
	assign ack_o                   = state.ack;
	assign ctl_request.launch      = state.launch;
	assign ctl_request.code        = state.code;
	assign ctl_request.address     = state.address;
	assign command_complete_flag   = idle;
	assign protection_open         = state.protection_open;
	assign protection_size         = state.protection_size;
	assign nonvolatile_option_bits = state.option;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	a_open_stays_closed: assert property (
		(state.nv_loaded && !state.protection_open) |=> !state.protection_open
	) else $error("protection open bit went from 0 to 1");

	a_size_never_shrinks: assert property (
		state.nv_loaded |=> (state.protection_size >= $past(state.protection_size))
	) else $error("protection size decreased");

	a_reduce_write_dropped: assert property (
		(state.nv_loaded && prot_wr && (dat_i[3:0] < state.protection_size))
		|=> $stable(state.protection_open) && $stable(state.protection_size)
	) else $error("reducing protection write changed the register");

	a_fault_protects_all: assert property (
		(nv_load && !state.nv_loaded && nv_protection_fault)
		|=> (!protection_open && protection_size == 4'hf)
	) else $error("protection fault did not protect all data flash");

	a_option_fault_ones: assert property (
		(nv_load && !state.nv_loaded && nv_option_fault) |=> nonvolatile_option_bits == 8'hff
	) else $error("option fault did not set all bits");

	a_launch_clears_flag: assert property (
		ctl_request.launch |-> (!command_complete_flag && $past(command_complete_flag))
	) else $error("launch without complete flag falling");

	a_fields_locked_busy: assert property (
		(!command_complete_flag ##1 !command_complete_flag)
		|-> ($stable(state.index) && $stable(ctl_request.code) && $stable(ctl_request.address))
	) else $error("command object changed while busy");

	a_violation_no_launch: assert property (
		(launch_req && refuse) |=> (state.violation && !ctl_request.launch && command_complete_flag)
	) else $error("protected command was launched");

	a_unused_index_zero: assert property (
		(rd && reg_idx == flash_regs_pkg::IDX_COMMAND_OBJECT && !index_valid)
		|=> (ack_o && dat_o == 32'h00000000)
	) else $error("unused command index read nonzero");

	a_reserved_read_zero: assert property (
		(rd && reg_idx >= flash_regs_pkg::IDX_FACTORY_RESERVED_1 &&
		 reg_idx <= flash_regs_pkg::IDX_FACTORY_RESERVED_4) |=> (ack_o && dat_o == 32'h00000000)
	) else $error("reserved register read nonzero");

endmodule : flash_protect_cmd_regs

// ===== pkg/flash_regs_pkg.sv
// constants, types and reset values for the flash protection and command object registers
package flash_regs_pkg;

	// wishbone byte address width in bits; each register takes one aligned word
	localparam int          ADR_W = 12;
	localparam int          IDX_W = 10;

	// register indices, byte address is four times the index
	localparam logic [9:0]  IDX_COMMAND_INDEX      = 10'h102;
	localparam logic [9:0]  IDX_FLASH_STATUS       = 10'h106;
	localparam logic [9:0]  IDX_DFLASH_PROTECTION  = 10'h109;
	localparam logic [9:0]  IDX_COMMAND_OBJECT     = 10'h10a;
	localparam logic [9:0]  IDX_FACTORY_RESERVED_1 = 10'h10c;
	localparam logic [9:0]  IDX_FACTORY_RESERVED_2 = 10'h10d;
	localparam logic [9:0]  IDX_FACTORY_RESERVED_3 = 10'h10e;
	localparam logic [9:0]  IDX_FACTORY_RESERVED_4 = 10'h10f;
	localparam logic [9:0]  IDX_NV_OPTION_BYTE     = 10'h110;
	localparam logic [9:0]  IDX_FACTORY_RESERVED_5 = 10'h111;
	localparam logic [9:0]  IDX_FACTORY_RESERVED_6 = 10'h112;
	localparam logic [9:0]  IDX_FACTORY_RESERVED_7 = 10'h113;

	// field positions
	localparam int          PROTECTION_OPEN_BIT    = 7;
	localparam int          COMPLETE_FLAG_BIT      = 7;
	localparam int          ACCESS_ERROR_BIT       = 5;
	localparam int          VIOLATION_BIT          = 4;

	// reset and fault values
	localparam logic [7:0]  PROTECTION_RESET       = 8'h0f;
	localparam logic [7:0]  PROTECTION_FAULT       = 8'h0f;
	localparam logic [7:0]  OPTION_RESET           = 8'hff;
	localparam logic [7:0]  OPTION_FAULT           = 8'hff;

	// data flash map
	localparam logic [17:0] DFLASH_BASE            = 18'h04400;
	localparam logic [17:0] DFLASH_LAST            = 18'h053ff;

	// command object layout
	localparam int          COB_WORDS              = 6;
	localparam int          COB_WIDTH              = 16;
	localparam logic [2:0]  COB_IDX_CODE           = 3'h0;
	localparam logic [2:0]  COB_IDX_ADDRESS        = 3'h1;
	localparam logic [2:0]  COB_IDX_LIMIT          = 3'h6;

	// command codes checked against protection
	localparam logic [7:0]  CMD_ERASE_ALL          = 8'h08;
	localparam logic [7:0]  CMD_ERASE_BLOCK        = 8'h09;
	localparam logic [7:0]  CMD_PROGRAM_DFLASH     = 8'h11;
	localparam logic [7:0]  CMD_ERASE_DFLASH_SECT  = 8'h12;

	typedef enum logic [1:0] {
		CMD_IDLE = 2'b01,
		CMD_BUSY = 2'b10
	} cmd_state_type;

	typedef struct packed {
		logic        launch;
		logic [7:0]  code;
		logic [17:0] address;
	} controller_request_type;

	typedef struct packed {
		logic        done;
		logic        wr_en;
		logic [2:0]  wr_index;
		logic [15:0] wr_data;
		logic        access_error;
	} controller_result_type;

	typedef struct packed {
		cmd_state_type cmd_state;
		logic [2:0]    index;
		logic          access_error;
		logic          violation;
		logic          protection_open;
		logic [3:0]    protection_size;
		logic [7:0]    option;
		logic          nv_loaded;
		logic [7:0]    code;
		logic [17:0]   address;
		logic          launch;
		logic          ack;
		logic [31:0]   dat;
	} regs_state_type;

	localparam regs_state_type STATE_RESET = '{
		cmd_state:       CMD_IDLE,
		index:           3'h0,
		access_error:    1'b0,
		violation:       1'b0,
		protection_open: PROTECTION_RESET[7],
		protection_size: PROTECTION_RESET[3:0],
		option:          OPTION_RESET,
		nv_loaded:       1'b0,
		code:            8'h00,
		address:         18'h00000,
		launch:          1'b0,
		ack:             1'b0,
		dat:             32'h00000000
	};

endpackage : flash_regs_pkg

// ===== verilog/command_object_store.sv
// six-word command object memory with registered read ports
module command_object_store #(
	parameter int WORDS = 6,
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_b,
	// write port with byte enables
	input  wire logic             wr_en,
	input  wire logic [2:0]       wr_index,
	input  wire logic [1:0]       wr_byte_en,
	input  wire logic [WIDTH-1:0] wr_data,
	// register-side read port
	input  wire logic [2:0]       rd_a_index,
	output logic      [WIDTH-1:0] rd_a_data,
	// controller-side read port
	input  wire logic [2:0]       rd_b_index,
	output logic      [WIDTH-1:0] rd_b_data
);

	typedef struct packed {
		logic [WORDS-1:0][WIDTH-1:0] word;
		logic [WIDTH-1:0]            rd_a;
		logic [WIDTH-1:0]            rd_b;
	} store_type;

	store_type state;
	store_type next_state;

	always_comb begin
		next_state = state;
		for (int i = 0; i < WORDS; i++) begin
			if (wr_en && wr_index == 3'(i)) begin
				if (wr_byte_en[0]) begin
					next_state.word[i][7:0] = wr_data[7:0];
				end
				if (wr_byte_en[1]) begin
					next_state.word[i][WIDTH-1:8] = wr_data[WIDTH-1:8];
				end
			end
		end
		// unimplemented entries read as zero
		next_state.rd_a = (32'(rd_a_index) < WORDS) ? state.word[rd_a_index] : '0;
		next_state.rd_b = (32'(rd_b_index) < WORDS) ? state.word[rd_b_index] : '0;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign rd_a_data = state.rd_a;
	assign rd_b_data = state.rd_b;

endmodule : command_object_store

// ===== tb/flash_controller_model.sv
// behavioural memory controller answering launches after a set delay
module flash_controller_model (
	// clock and reset
	input  wire logic                                   clock,
	input  wire logic                                   rst_b,
	// command handshake
	input  wire flash_regs_pkg::controller_request_type ctl_request,
	input  wire logic [4:0]                             delay,
	output flash_regs_pkg::controller_result_type       ctl_result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       busy;
	logic [4:0] cnt;
	always @(posedge clock) begin
		if (!rst_b) begin
			busy <= 1'b0;
			cnt <= 5'h00;
			ctl_result <= '0;
		end else if (ctl_request.launch) begin
			busy <= 1'b1;
			cnt <= delay;
			ctl_result <= '0;
		end else if (busy) begin
			cnt <= cnt - 5'h01;
			// result word placed before completion
			if (cnt == 5'h02) begin
				ctl_result <= '{1'b0, 1'b1, 3'h2, 16'hbeef, 1'b0};
			end else if (cnt == 5'h01) begin
				ctl_result <= '{1'b1, 1'b0, 3'h0, 16'h0000, 1'b0};
				busy <= 1'b0;
			end else begin
				ctl_result <= '0;
			end
		end else begin
			ctl_result <= '0;
		end
	end
endmodule : flash_controller_model

// ===== tb/flash_protect_cmd_regs_tb.sv
// self-checking bench for the flash protection and command object registers
module flash_protect_cmd_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst_b, cyc_i, stb_i, we_i, ack_o, nv_load, nv_protection_fault, nv_option_fault;
	logic [11:0] adr_i;
	logic [3:0]  sel_i, protection_size;
	logic [31:0] dat_i, dat_o, rd;
	logic [7:0]  nv_protection_byte, nv_option_byte, nonvolatile_option_bits;
	logic [2:0]  ctl_rd_index;
	logic [15:0] ctl_rd_data;
	logic [4:0]  delay;
	logic        command_complete_flag, protection_open;
	flash_regs_pkg::controller_request_type ctl_request;
	flash_regs_pkg::controller_result_type  ctl_result;
	int error_cnt, checked, launches;
	localparam logic [9:0] ST = flash_regs_pkg::IDX_FLASH_STATUS;
	localparam logic [9:0] CI = flash_regs_pkg::IDX_COMMAND_INDEX;
	localparam logic [9:0] CO = flash_regs_pkg::IDX_COMMAND_OBJECT;
	localparam logic [9:0] PR = flash_regs_pkg::IDX_DFLASH_PROTECTION;
	flash_protect_cmd_regs flash_protect_cmd_regs_inst (.clock(clock), .rst_b(rst_b),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .nv_load(nv_load), .nv_protection_byte(nv_protection_byte),
		.nv_protection_fault(nv_protection_fault), .nv_option_byte(nv_option_byte),
		.nv_option_fault(nv_option_fault), .ctl_request(ctl_request), .ctl_result(ctl_result),
		.ctl_rd_index(ctl_rd_index), .ctl_rd_data(ctl_rd_data),
		.command_complete_flag(command_complete_flag), .protection_open(protection_open),
		.protection_size(protection_size), .nonvolatile_option_bits(nonvolatile_option_bits));
	flash_controller_model flash_controller_model_inst (.clock(clock), .rst_b(rst_b),
		.ctl_request(ctl_request), .delay(delay), .ctl_result(ctl_result));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) if (ctl_request.launch === 1'b1) launches++;
	task test_done;
		if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one classic cycle; held until ack is seen at a rising edge
	task wb(input logic w, input logic [9:0] i, input logic [1:0] s, input logic [15:0] d);
		@(posedge clock);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {i, 2'b00};
		sel_i <= {2'b00, s};
		dat_i <= {16'h0000, d};
		@(posedge clock);
		while (ack_o !== 1'b1) @(posedge clock);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	task rdchk(input logic [9:0] i, input logic [31:0] e);
		wb(1'b0, i, 2'b11, 16'h0000);
		chk(rd, e);
	endtask : rdchk
	task nv_pulse(input logic [7:0] p, input logic [7:0] o, input logic f);
		@(posedge clock);
		{nv_load, nv_protection_byte, nv_option_byte} <= {1'b1, p, o};
		{nv_protection_fault, nv_option_fault} <= {f, f};
		@(posedge clock);
		nv_load <= 1'b0;
	endtask : nv_pulse
	task t_load;
		nv_pulse(8'h00, 8'h00, 1'b1);
		rdchk(PR, 32'h0f);
		rdchk(flash_regs_pkg::IDX_NV_OPTION_BYTE, 32'hff);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		nv_pulse(8'h93, 8'h5a, 1'b0);
		nv_pulse(8'h00, 8'h00, 1'b0);
		rdchk(PR, 32'h83);
		chk(nonvolatile_option_bits, 8'h5a);
	endtask : t_load
	task t_protect;
		logic [7:0] w [5];
		logic [7:0] e [5];
		w = '{8'h82, 8'h05, 8'h85, 8'h74, 8'h77};
		e = '{8'h83, 8'h05, 8'h05, 8'h05, 8'h07};
		for (int k = 0; k < 5; k++) begin
			wb(1'b1, PR, 2'b01, {8'h00, w[k]});
			rdchk(PR, {24'h0, e[k]});
		end
		chk({protection_open, protection_size}, 5'h07);
	endtask : t_protect
	task t_reserved;
		logic [9:0] r [8];
		r = '{10'h10c, 10'h10d, 10'h10e, 10'h10f, 10'h111, 10'h112, 10'h113, 10'h0ff};
		for (int k = 0; k < 8; k++) begin
			wb(1'b1, r[k], 2'b11, 16'hffff);
			rdchk(r[k], 32'h0);
		end
		wb(1'b1, flash_regs_pkg::IDX_NV_OPTION_BYTE, 2'b01, 16'h0000);
		rdchk(flash_regs_pkg::IDX_NV_OPTION_BYTE, 32'h5a);
	endtask : t_reserved
	task load(input logic [7:0] code, input logic [15:0] a);
		wb(1'b1, CI, 2'b01, 16'h0000);
		wb(1'b1, CO, 2'b10, {code, 8'h00});
		wb(1'b1, CO, 2'b01, 16'h00ff);
		rdchk(CO, {16'h0, code, 8'h03});
		wb(1'b1, CO, 2'b01, 16'h0000);
		wb(1'b1, CI, 2'b01, 16'h0001);
		wb(1'b1, CO, 2'b11, a);
	endtask : load
	task t_unimpl;
		for (int k = 6; k < 8; k++) begin
			wb(1'b1, CI, 2'b01, k[15:0]);
			wb(1'b1, CO, 2'b11, 16'hffff);
			rdchk(CO, 32'h0);
			ctl_rd_index <= k[2:0];
			repeat (2) @(posedge clock);
			chk(ctl_rd_data, 16'h0000);
		end
	endtask : t_unimpl
	task t_launch;
		load(8'h11, 16'h5000);
		wb(1'b1, ST, 2'b01, 16'h0080);
		chk(command_complete_flag, 1'b0);
		chk({ctl_request.code, ctl_request.address}, {8'h11, 18'h05000});
		wb(1'b1, CO, 2'b11, 16'hffff);
		wb(1'b1, ST, 2'b01, 16'h0080);
		rdchk(CO, 32'h5000);
		while (command_complete_flag !== 1'b1) @(negedge clock);
		chk(launches, 1);
		wb(1'b1, CI, 2'b01, 16'h0002);
		rdchk(CO, 32'hbeef);
		ctl_rd_index <= 3'h2;
		repeat (2) @(posedge clock);
		chk(ctl_rd_data, 16'hbeef);
		delay <= 5'h01;
		wb(1'b1, ST, 2'b01, 16'h0080);
		repeat (4) @(posedge clock);
		chk({launches[1:0], command_complete_flag}, 3'h5);
	endtask : t_launch
	task t_refuse;
		logic [7:0]  c [4];
		logic [15:0] a [4];
		c = '{8'h11, 8'h12, 8'h09, 8'h08};
		a = '{16'h4400, 16'h4bff, 16'h5000, 16'h0000};
		for (int k = 0; k < 4; k++) begin
			load(c[k], a[k]);
			wb(1'b1, ST, 2'b01, 16'h0080);
			rdchk(ST, 32'h90);
			chk(launches, 2);
			wb(1'b1, ST, 2'b01, 16'h0010);
			rdchk(ST, 32'h80);
		end
	endtask : t_refuse
	initial begin
		{rst_b, cyc_i, stb_i, we_i, nv_load, nv_protection_fault, nv_option_fault} = '0;
		{adr_i, sel_i, dat_i, nv_protection_byte, nv_option_byte, ctl_rd_index} = '0;
		delay = 5'h14;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		t_load;
		t_protect;
		t_reserved;
		t_unimpl;
		t_launch;
		t_refuse;
		test_done;
	end
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		test_done;
	end
endmodule : flash_protect_cmd_regs_tb
